// [wlp_ctrl.sv]
/*
  Watchdog with key service and low-power mode controller, AHB-Lite slave.
  Assumes single transfers, one clock, and synchronous pin inputs.
*/
// Design decisions made here: the AHB-Lite register port and the register addresses.
// Function
// - 8-bit counter, 512-cycle pulse at maximum
// - Reset output active low, 512 cycles
// - Key 55 then AA clears counter
// - Counter holds while running on limp clock
// - Substitute limp clock when input clock fails
// - Watchdog interrupt wakes STANDBY when enabled
// - Watchdog pulse ends IDLE directly, in reset or interrupt mode
// - Watchdog pulse ends HALT, in reset or interrupt mode
// - Only watchdog runs in STANDBY
// - Mode field 00 IDLE, 01 STANDBY, 1X HALT
// - IDLE clocks run; STANDBY stops CPU, system
// - HALT stops oscillator, CPU, system clocks
// - STANDBY exits: reset, watchdog, GPIO, debugger
// - HALT exits: reset, GPIO, debugger, watchdog
// - Wake is active low, must stay qualified
// - Debug port works with CPU clock stopped
// - HALT entered only with watchdog clock active
// - IDLE: block idle, ends on enabled interrupt
// - STANDBY wake by selected, qualified GPIO lines
// - Output pins keep level across modes
module wlp_ctrl #(
  parameter int PULSE_LEN = wlp_pkg::PULSE_CYCLES
) (
  // Bus
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Clock status and wake sources
  input  wire logic        input_clock_ok,
  input  wire logic        watchdog_clock_on,
  input  wire logic        cpu_irq_pending,
  input  wire logic        external_reset_pin_n,
  input  wire logic        debugger_wake_n,
  input  wire logic [31:0] gpio_a_in,
  // Outputs
  output logic             watchdog_reset_out_n,
  output logic             watchdog_irq_out_n,
  output logic             watchdog_pie_irq,
  output logic             cpu_clock_en,
  output logic             system_clock_en,
  output logic             crystal_pll_en,
  output logic             limp_clock_sel,
  output logic             peripherals_on,
  output logic             debug_port_on,
  output logic [1:0]       lp_state
);
  localparam int PW = $clog2(PULSE_LEN + 1);
  initial
  begin
    if (PULSE_LEN < 2)
      $error("PULSE_LEN too small");
  end

  // Bus address phase capture
  logic       wr_ff;
  logic [7:0] addr_ff;
  wire        acc = hsel & htrans[1] & hready;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ff   <= 1'b0;
      addr_ff <= 8'h00;
    end
    else
    begin
      wr_ff   <= acc & hwrite;
      addr_ff <= haddr;
    end
  end
  wire wr_ctrl  = wr_ff & (addr_ff == wlp_pkg::ADDR_WD_CTRL);
  wire wr_key   = wr_ff & (addr_ff == wlp_pkg::ADDR_WD_KEY);
  wire wr_lpc   = wr_ff & (addr_ff == wlp_pkg::ADDR_LPM_CTRL);
  wire wr_wsel  = wr_ff & (addr_ff == wlp_pkg::ADDR_WAKE_SEL);
  wire wr_enter = wr_ff & (addr_ff == wlp_pkg::ADDR_ENTER);

  // Registers
  logic [7:0]  wdc_ff, cnt_ff, key_wd;
  logic        armed_ff, flag_ff;
  logic [8:0]  lpc_ff;
  logic [31:0] wsel_ff;
  logic [PW-1:0] pulse_ff;
  // Local names for the package's state codes
  localparam wlp_pkg::wlp_state_t LP_RUN     = wlp_pkg::LP_RUN;
  localparam wlp_pkg::wlp_state_t LP_IDLE    = wlp_pkg::LP_IDLE;
  localparam wlp_pkg::wlp_state_t LP_STANDBY = wlp_pkg::LP_STANDBY;
  localparam wlp_pkg::wlp_state_t LP_HALT    = wlp_pkg::LP_HALT;
  wlp_pkg::wlp_state_t st_ff, nxt_st;
  assign key_wd = hwdata[7:0];

  wire wd_dis   = wdc_ff[wlp_pkg::WDC_DIS_BIT];
  wire wd_irqm  = wdc_ff[wlp_pkg::WDC_IRQ_BIT];
  wire wd_halt  = wdc_ff[wlp_pkg::WDC_HALT_BIT];
  wire key_good = wr_key & armed_ff & (key_wd == wlp_pkg::KEY_SECOND);
  wire expire   = ~wd_dis & (cnt_ff == 8'hFF) & (pulse_ff == '0);
  // Watchdog ticks only with real input clock, and in HALT only if kept on
  wire tick     = input_clock_ok & ~wd_dis & (pulse_ff == '0)
                & ((st_ff != LP_HALT) | wd_halt);
  wire pulsing  = pulse_ff != '0;
  wire wd_wake_n = ~(pulsing & wd_irqm);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wdc_ff   <= wlp_pkg::WDC_RST;
      armed_ff <= 1'b0;
      cnt_ff   <= wlp_pkg::CNT_RST;
      pulse_ff <= '0;
      flag_ff  <= 1'b0;
      lpc_ff   <= wlp_pkg::LPC_RST;
      wsel_ff  <= wlp_pkg::WSEL_RST;
    end
    else
    begin
      if (wr_ctrl)
        wdc_ff <= {5'h00, hwdata[2:0]};
      if (wr_key)
        armed_ff <= (key_wd == wlp_pkg::KEY_FIRST);
      if (key_good || expire)
        cnt_ff <= wlp_pkg::CNT_RST;
      else if (tick)
        cnt_ff <= cnt_ff + 8'h01;
      if (expire)
        pulse_ff <= PW'(PULSE_LEN - 1);
      else if (pulsing)
        pulse_ff <= pulse_ff - PW'(1);
      // Event flag: set wins over clear
      if (expire)
        flag_ff <= 1'b1;
      else if (wr_ctrl && hwdata[wlp_pkg::WDC_FLAG_BIT])
        flag_ff <= 1'b0;
      if (wr_lpc)
        lpc_ff <= hwdata[8:0];
      if (wr_wsel)
        wsel_ff <= hwdata;
    end
  end

  // Wake qualification: selected lines low for the programmed count
  logic [5:0] qual_ff;
  wire [5:0] qual_n = lpc_ff[wlp_pkg::LPC_QUAL_LSB +: 6];
  wire gpio_low = |(wsel_ff & ~gpio_a_in);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      qual_ff <= 6'h00;
    else if (gpio_low && (st_ff == LP_STANDBY || st_ff == LP_HALT))
      qual_ff <= (qual_ff == 6'h3F) ? qual_ff : qual_ff + 6'h01;
    else
      qual_ff <= 6'h00;
  end
  wire gpio_wake = gpio_low & (qual_ff >= qual_n);
  wire common_wake = ~external_reset_pin_n | ~debugger_wake_n;
  wire lpc_wdwake  = lpc_ff[wlp_pkg::LPC_WDWAKE_BIT];
  wire [1:0] mode  = lpc_ff[wlp_pkg::LPC_MODE_LSB +: 2];

  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      LP_RUN:
        if (wr_enter)
        begin
          if (mode == wlp_pkg::MODE_IDLE)
            nxt_st = LP_IDLE;
          else if (mode == wlp_pkg::MODE_STANDBY)
            nxt_st = LP_STANDBY;
          else if (watchdog_clock_on)
            nxt_st = LP_HALT;
        end
      LP_IDLE:
        if (cpu_irq_pending || pulsing || !external_reset_pin_n)
          nxt_st = LP_RUN;
      LP_STANDBY:
        if (common_wake || gpio_wake || (lpc_wdwake && !wd_wake_n))
          nxt_st = LP_RUN;
      LP_HALT:
        if (common_wake || gpio_wake || pulsing)
          nxt_st = LP_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff                <= LP_RUN;
      watchdog_reset_out_n <= 1'b1;
      watchdog_irq_out_n   <= 1'b1;
      watchdog_pie_irq     <= 1'b0;
      cpu_clock_en         <= 1'b1;
      system_clock_en      <= 1'b1;
      crystal_pll_en       <= 1'b1;
      limp_clock_sel       <= 1'b0;
      peripherals_on       <= 1'b1;
      debug_port_on        <= 1'b1;
      lp_state             <= 2'h0;
      hrdata               <= 32'h0000_0000;
      hreadyout            <= 1'b1;
      hresp                <= 1'b0;
    end
    else
    begin
      st_ff                <= nxt_st;
      watchdog_reset_out_n <= ~((expire | pulsing) & ~wd_irqm);
      watchdog_irq_out_n   <= ~((expire | pulsing) & wd_irqm);
      watchdog_pie_irq     <= (expire | pulsing) & wd_irqm;
      cpu_clock_en         <= (nxt_st == LP_RUN) | (nxt_st == LP_IDLE);
      system_clock_en      <= (nxt_st == LP_RUN) | (nxt_st == LP_IDLE);
      crystal_pll_en       <= nxt_st != LP_HALT;
      limp_clock_sel       <= ~input_clock_ok;
      peripherals_on       <= (nxt_st == LP_RUN) | (nxt_st == LP_IDLE);
      debug_port_on        <= 1'b1;
      lp_state             <= nxt_st;
      hreadyout            <= 1'b1;
      hresp                <= 1'b0;
      if (acc && !hwrite)
        unique case (haddr)
          wlp_pkg::ADDR_WD_CTRL:  hrdata <= {28'h0, flag_ff, wdc_ff[2:0]};
          wlp_pkg::ADDR_WD_CNT:   hrdata <= {24'h0, cnt_ff};
          wlp_pkg::ADDR_LPM_CTRL: hrdata <= {23'h0, lpc_ff};
          wlp_pkg::ADDR_WAKE_SEL: hrdata <= wsel_ff;
          wlp_pkg::ADDR_LPM_STAT: hrdata <= {30'h0, st_ff};
          default:                hrdata <= 32'h0000_0000;
        endcase
    end
  end
  // Pin levels elsewhere are untouched: this block drives no GPIO

  // Expiry in reset mode and in interrupt mode
  sequence s_fire;
    expire && !wd_irqm;
  endsequence
  sequence s_irq_fire;
    expire && wd_irqm;
  endsequence
  a_pulse_len: assert property (
    @(posedge hclk) disable iff (!hresetn)
    expire |=> (pulse_ff == PW'(PULSE_LEN - 1)))
    else $error("bad pulse");
  a_rst_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_fire |=> !watchdog_reset_out_n[*8])
    else $error("reset not low");
  a_key_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    key_good |=> cnt_ff == 8'h00)
    else $error("key no clear");
  a_bad_key: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_key && !key_good && !tick && !expire) |=> $stable(cnt_ff))
    else $error("bad key moved count");
  a_limp_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!input_clock_ok && !key_good && !expire) |=> $stable(cnt_ff))
    else $error("count moved in limp");
  a_halt_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_RUN && nxt_st == LP_HALT) |-> watchdog_clock_on)
    else $error("halt without clock");
  a_stby_clk: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_STANDBY) |-> !cpu_clock_en && !system_clock_en)
    else $error("clock on in standby");
  a_halt_wake: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_HALT && !external_reset_pin_n) |=> st_ff == LP_RUN)
    else $error("halt not left");
  a_irq_low: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_irq_fire |=> !watchdog_irq_out_n[*8])
    else $error("irq not low");
  a_irq_no_rst: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_irq_fire |=> watchdog_reset_out_n)
    else $error("reset in irq mode");
  a_pie_copy: assert property (
    @(posedge hclk) disable iff (!hresetn)
    watchdog_pie_irq != watchdog_irq_out_n)
    else $error("irq copy differs");
  a_cnt_step: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (tick && !key_good && !expire) |=> cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("count did not step");
  a_dis_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wd_dis && !key_good) |=> $stable(cnt_ff))
    else $error("disabled count moved");
  a_pulse_down: assert property (
    @(posedge hclk) disable iff (!hresetn)
    pulsing |=> pulse_ff == $past(pulse_ff) - PW'(1))
    else $error("pulse count wrong");
  a_limp_on: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !input_clock_ok |=> limp_clock_sel)
    else $error("limp not selected");
  a_limp_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    input_clock_ok |=> !limp_clock_sel)
    else $error("limp stuck");
  a_dbg_on: assert property (
    @(posedge hclk) disable iff (!hresetn)
    debug_port_on)
    else $error("debug port off");
  a_idle_clk: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_IDLE) |-> cpu_clock_en && system_clock_en && crystal_pll_en)
    else $error("clock off in idle");
  a_halt_clk: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_HALT) |-> !crystal_pll_en && !cpu_clock_en && !system_clock_en)
    else $error("clock on in halt");
  a_stby_per: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_STANDBY) |-> !peripherals_on && crystal_pll_en)
    else $error("peripherals on in standby");
  a_run_clk: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_RUN) |-> cpu_clock_en && peripherals_on)
    else $error("clock off in run");
  a_state_out: assert property (
    @(posedge hclk) disable iff (!hresetn)
    lp_state == st_ff)
    else $error("state output differs");
  a_mode_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_RUN && wr_enter && mode == 2'h0) |=> st_ff == LP_IDLE)
    else $error("idle not entered");
  a_mode_stby: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_RUN && wr_enter && mode == 2'h1) |=> st_ff == LP_STANDBY)
    else $error("standby not entered");
  a_mode_halt: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_RUN && wr_enter && mode[1] && watchdog_clock_on)
    |=> st_ff == LP_HALT) else $error("halt not entered");
  a_idle_stay: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_IDLE && !cpu_irq_pending && !pulsing && external_reset_pin_n)
    |=> st_ff == LP_IDLE) else $error("idle left early");
  a_idle_irq: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_IDLE && cpu_irq_pending) |=> st_ff == LP_RUN)
    else $error("idle not left");
  a_stby_wd: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_STANDBY && lpc_wdwake && !wd_wake_n) |=> st_ff == LP_RUN)
    else $error("watchdog did not wake");
  a_stby_dbg: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_STANDBY && !debugger_wake_n) |=> st_ff == LP_RUN)
    else $error("debugger did not wake");
  a_stby_gpio: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_STANDBY && gpio_wake) |=> st_ff == LP_RUN)
    else $error("pin did not wake");
  a_stby_only: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_STANDBY && !common_wake && !gpio_wake
     && !(lpc_wdwake && !wd_wake_n)) |=> st_ff == LP_STANDBY)
    else $error("standby left unasked");
  a_halt_wd: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_HALT && pulsing) |=> st_ff == LP_RUN)
    else $error("watchdog did not end halt");
  a_halt_gpio: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_HALT && gpio_wake) |=> st_ff == LP_RUN)
    else $error("pin did not end halt");
  a_qual_clr: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !gpio_low |=> qual_ff == 6'h00)
    else $error("qualifier not cleared");
  a_halt_tick: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (st_ff == LP_HALT && !wd_halt && !key_good && !expire) |=> $stable(cnt_ff))
    else $error("count moved in halt");
endmodule // wlp_ctrl

// [wlp_ctrl_tb.sv]
/*
  Self-checking bench for wlp_ctrl driven through the software model.
  Assumes a 10 MHz clock and a shortened expiry pulse.
*/
module wlp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PL = 8;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] src;
    logic [1:0] st;
    logic [3:0] en;
  } wlp_row_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans, lp_state;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, gpio_a_in, q, q2;
  logic        input_clock_ok, watchdog_clock_on, cpu_irq_pending;
  logic        external_reset_pin_n, debugger_wake_n;
  logic        watchdog_reset_out_n, watchdog_irq_out_n, watchdog_pie_irq;
  logic        cpu_clock_en, system_clock_en, crystal_pll_en;
  logic        limp_clock_sel, peripherals_on, debug_port_on;
  int          fail_count = 0;
  int          cmp_count = 0;
  // Mode, wake source, state, {cpu, system, crystal, peripherals}
  wlp_row_t    rows [6] = '{'{2'h0, 2'h0, 2'h1, 4'hF},
                            '{2'h1, 2'h1, 2'h2, 4'h2},
                            '{2'h1, 2'h2, 2'h2, 4'h2},
                            '{2'h2, 2'h3, 2'h3, 4'h0},
                            '{2'h3, 2'h2, 2'h3, 4'h0},
                            '{2'h2, 2'h1, 2'h3, 4'h0}};

  wlp_sw_model sw (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize,
                   .hwdata, .hready(hreadyout), .hrdata);
  wlp_ctrl #(.PULSE_LEN(PL)) uut (.*, .hready(hreadyout));

  initial hclk = 1'h0;
  always #50 hclk = ~hclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_st(input logic [1:0] exp);
    int t = 0;
    do @(posedge hclk); while (lp_state !== exp && ++t < 600);
    chk(lp_state, exp);
  endtask
  function automatic logic pin(input bit irq);
    return irq ? watchdog_irq_out_n : watchdog_reset_out_n;
  endfunction
  // Measures how many cycles the selected output stays low
  task automatic pulse(input bit irq);
    int t = 0;
    int n = 1;
    do @(posedge hclk); while (pin(irq) !== 1'h0 && ++t < 2000);
    if (irq) chk(watchdog_pie_irq, 1'h1);
    do @(posedge hclk); while (pin(irq) === 1'h0 && ++n < 2000);
    chk(n, PL);
  endtask

  initial
  begin
    #3_000_000;
    fail_count++;
    end_of_test;
  end

  initial
  begin
    hresetn = 1'h0;
    input_clock_ok = 1'h1;
    watchdog_clock_on = 1'h1;
    cpu_irq_pending = 1'h0;
    external_reset_pin_n = 1'h1;
    debugger_wake_n = 1'h1;
    gpio_a_in = 32'hFFFF_FFFF;
    repeat (3) @(posedge hclk);
    chk({watchdog_reset_out_n, watchdog_irq_out_n, cpu_clock_en,
         debug_port_on, lp_state, hreadyout, hresp}, 8'hF2);
    hresetn <= 1'h1;
    @(posedge hclk);
    sw.wr(wlp_pkg::ADDR_WD_CTRL, 32'h1);
    sw.wr(wlp_pkg::ADDR_WAKE_SEL, 32'h20);
    foreach (rows[i])
    begin
      sw.wr(wlp_pkg::ADDR_LPM_CTRL, {24'h0, 6'h02, rows[i].mode});
      sw.wr(wlp_pkg::ADDR_ENTER, 32'h1);
      repeat (3) @(posedge hclk);
      chk({lp_state, cpu_clock_en, system_clock_en, crystal_pll_en,
           peripherals_on, debug_port_on},
          {rows[i].st, rows[i].en, 1'h1});
      case (rows[i].src)
        2'h0: cpu_irq_pending <= 1'h1;
        2'h1: debugger_wake_n <= 1'h0;
        2'h2: gpio_a_in[5] <= 1'h0;
        default: external_reset_pin_n <= 1'h0;
      endcase
      repeat (20) @(posedge hclk);
      cpu_irq_pending <= 1'h0;
      debugger_wake_n <= 1'h1;
      gpio_a_in <= 32'hFFFF_FFFF;
      external_reset_pin_n <= 1'h1;
      wait_st(2'h0);
    end
    watchdog_clock_on <= 1'h0;
    sw.wr(wlp_pkg::ADDR_LPM_CTRL, 32'h2);
    sw.wr(wlp_pkg::ADDR_ENTER, 32'h1);
    repeat (3) @(posedge hclk);
    chk(lp_state, 2'h0);
    watchdog_clock_on <= 1'h1;
    sw.wr(wlp_pkg::ADDR_WD_CTRL, 32'h0);
    sw.wr(wlp_pkg::ADDR_WD_KEY, {24'h0, wlp_pkg::KEY_FIRST});
    sw.wr(wlp_pkg::ADDR_WD_KEY, {24'h0, wlp_pkg::KEY_SECOND});
    sw.rd(wlp_pkg::ADDR_WD_CNT, q);
    chk(q < 32'h10, 1'h1);
    repeat (60) @(posedge hclk);
    sw.wr(wlp_pkg::ADDR_WD_KEY, {24'h0, wlp_pkg::KEY_FIRST});
    sw.wr(wlp_pkg::ADDR_WD_KEY, 32'h12);
    sw.wr(wlp_pkg::ADDR_WD_KEY, {24'h0, wlp_pkg::KEY_SECOND});
    sw.rd(wlp_pkg::ADDR_WD_CNT, q);
    chk(q > 32'h40, 1'h1);
    input_clock_ok <= 1'h0;
    sw.rd(wlp_pkg::ADDR_WD_CNT, q);
    repeat (30) @(posedge hclk);
    sw.rd(wlp_pkg::ADDR_WD_CNT, q2);
    chk(q2, q);
    chk(limp_clock_sel, 1'h1);
    input_clock_ok <= 1'h1;
    pulse(1'h0);
    sw.wr(wlp_pkg::ADDR_WD_CTRL, 32'h2);
    pulse(1'h1);
    sw.wr(wlp_pkg::ADDR_LPM_CTRL, 32'h101);
    sw.wr(wlp_pkg::ADDR_ENTER, 32'h1);
    repeat (3) @(posedge hclk);
    chk(lp_state, 2'h2);
    wait_st(2'h0);
    end_of_test;
  end
endmodule // wlp_ctrl_tb

// [wlp_pkg.sv]
/*
  Constants shared by the watchdog and low-power controller.
  Assumes a single 10 MHz clock standing in for the oscillator clock.
*/
package wlp_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_WD_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_WD_KEY    = 8'h04;
  localparam logic [7:0] ADDR_WD_CNT    = 8'h08;
  localparam logic [7:0] ADDR_LPM_CTRL  = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_SEL  = 8'h10;
  localparam logic [7:0] ADDR_LPM_STAT  = 8'h14;
  localparam logic [7:0] ADDR_ENTER     = 8'h18;
  // Key values
  localparam logic [7:0] KEY_FIRST      = 8'h55;
  localparam logic [7:0] KEY_SECOND     = 8'hAA;
  // Watchdog control fields
  localparam int         WDC_DIS_BIT    = 0;
  localparam int         WDC_IRQ_BIT    = 1;
  localparam int         WDC_HALT_BIT   = 2;
  localparam int         WDC_FLAG_BIT   = 3;
  // Low-power control fields
  localparam int         LPC_MODE_LSB   = 0;
  localparam int         LPC_QUAL_LSB   = 2;
  localparam int         LPC_WDWAKE_BIT = 8;
  // Reset values
  localparam logic [7:0] CNT_RST        = 8'h00;
  localparam logic [7:0] WDC_RST        = 8'h00;
  localparam logic [8:0] LPC_RST        = 9'h000;
  localparam logic [31:0] WSEL_RST      = 32'h0000_0000;
  // Pulse width in oscillator clocks
  localparam int         PULSE_CYCLES   = 512;
  // Modes
  localparam logic [1:0] MODE_IDLE      = 2'h0;
  localparam logic [1:0] MODE_STANDBY   = 2'h1;
  typedef enum logic [1:0] {LP_RUN, LP_IDLE, LP_STANDBY, LP_HALT} wlp_state_t;
endpackage

// [wlp_sw_model.sv]
/*
  CPU software model: AHB-Lite master doing single word transfers.
  Assumes one slave whose hreadyout comes back as hready.
*/
module wlp_sw_model (
  // Clock
  input  wire logic        hclk,
  // Bus
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    hsel = 1'h0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // Entered and left just after a rising edge
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'h1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'h1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'h0, 32'h0000_0000, q);
  endtask
endmodule // wlp_sw_model
